/* File: verilog/swb_pkg.sv */
/*
  Constants shared by the single-wire byte read/write engine.
  Assumes a 20 MHz system clock; host link bits arrive MSB first.
*/
// Summary of operation
// - Write-byte code plus data byte sends that byte as eight slots.
// - Write-byte code arriving while busy: code and data unacknowledged, ignored.
// - Write-byte completes in eight slot periods plus at most 262.5 ns.
// - Bus waits for whole byte since host is MSB first, bus LSB first.
// - Write-byte bus activity starts within 262.5 ns of data LSB falling edge.
// - Busy flag stays high for eight slot periods during either byte command.
// - After either byte command the read pointer rests on status.
// - Write-byte uses current speed, strong pullup and active pullup settings.
// - Read-byte code, no parameter, makes eight read slots, stores result.
// - Each read slot is a write-one slot; one command gives eight bits.
// - Read-byte code arriving while busy is unacknowledged and discarded.
// - Read-byte starts within 262.5 ns, ends within eight slots plus that.
// - A write-one slot samples the bus level to get the returned bit.
package swb_pkg;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'hA5;
  localparam logic [7:0] CMD_READ_BYTE  = 8'h96;
  localparam int         CLK_MHZ        = 20;
  // Start latency 262.5 ns, in tenths of ns
  localparam int         LAT_NS_X10     = 2625;
  localparam int         LAT_CYC        = (LAT_NS_X10 * CLK_MHZ) / 10000;
  localparam int         TW             = 16;
  localparam logic [3:0] ACK_BIT        = 4'h8;
  localparam logic [2:0] LAST_IDX       = 3'h7;
  localparam int         SLOTS          = 8;
  localparam logic       PTR_RST        = 1'b1;

  // Least time in ns to cycles, rounded up, at least one
  function automatic logic [TW-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return TW'(c);
  endfunction
endpackage

/* File: verilog/swb_engine.sv */
/*
  Byte write/read command engine: takes command bytes from the host link
  (sampled clock, data, frame), drives the single-wire bus open-drain.
  Assumes frame_i is high for the length of one host transaction.
*/
`timescale 1ns/1ps
module swb_engine #(
  parameter int STD_SLOT_NS = 70000,
  parameter int STD_W0L_NS  = 60000,
  parameter int STD_W1L_NS  = 6000,
  parameter int STD_MSR_NS  = 10000,
  parameter int OD_SLOT_NS  = 10000,
  parameter int OD_W0L_NS   = 7500,
  parameter int OD_W1L_NS   = 1000,
  parameter int OD_MSR_NS   = 2000,
  parameter int APU_NS      = 500
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Host link
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       frame_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Configuration
  input  wire logic       overdrive_speed_select_i,
  input  wire logic       strong_pullup_enable_i,
  input  wire logic       active_pullup_enable_i,
  input  wire logic       ptr_sel_data_i,
  // Single-wire bus
  input  wire logic       ow_i,
  output logic            ow_o,
  output logic            ow_oe_o,
  output logic            spu_o,
  output logic            apu_o,
  // Status
  output logic            bus_busy_flag_o,
  output logic [7:0]      read_data_o,
  output logic            ptr_status_o
);
  localparam logic [swb_pkg::TW-1:0] STD_SLOT_C = swb_pkg::ns_to_cyc(STD_SLOT_NS);
  localparam logic [swb_pkg::TW-1:0] STD_W0L_C  = swb_pkg::ns_to_cyc(STD_W0L_NS);
  localparam logic [swb_pkg::TW-1:0] STD_W1L_C  = swb_pkg::ns_to_cyc(STD_W1L_NS);
  localparam logic [swb_pkg::TW-1:0] STD_MSR_C  = swb_pkg::ns_to_cyc(STD_MSR_NS);
  localparam logic [swb_pkg::TW-1:0] OD_SLOT_C  = swb_pkg::ns_to_cyc(OD_SLOT_NS);
  localparam logic [swb_pkg::TW-1:0] OD_W0L_C   = swb_pkg::ns_to_cyc(OD_W0L_NS);
  localparam logic [swb_pkg::TW-1:0] OD_W1L_C   = swb_pkg::ns_to_cyc(OD_W1L_NS);
  localparam logic [swb_pkg::TW-1:0] OD_MSR_C   = swb_pkg::ns_to_cyc(OD_MSR_NS);
  localparam logic [swb_pkg::TW-1:0] APU_C      = swb_pkg::ns_to_cyc(APU_NS);

  typedef enum logic [2:0] {H_IDLE, H_CODE, H_DATA, H_RWAIT, H_DROP} swb_host_t;
  typedef enum logic       {W_IDLE, W_SLOT} swb_wire_t;

  logic                    scl_m_r, scl_s_r, scl_d_r;
  logic                    sda_m_r, sda_s_r;
  logic                    frm_m_r, frm_s_r;
  logic                    ow_m_r, ow_s_r;
  swb_host_t               hst_r;
  swb_wire_t               wst_r;
  logic [3:0]              bit_cnt_r;
  logic [7:0]              sh_r;
  logic                    ack_ph_r;
  logic                    sda_oe_r;
  logic [swb_pkg::TW-1:0]  tmr_r;
  logic [2:0]              idx_r;
  logic [7:0]              tx_r;
  logic [7:0]              rx_r;
  logic [7:0]              rd_data_r;
  logic                    rd_cmd_r, od_r, spu_lat_r, apu_lat_r;
  logic                    busy_r, ow_oe_r, spu_r, apu_r, ptr_r;
  logic                    zero_r;
  logic [swb_pkg::TW+3:0]  busy_cyc_r;

  logic                    scl_rise, scl_fall, lsb_fall, ack_fall;
  logic                    code_wr, code_rd, go_wr, go_rd, start, ack_go;
  logic [swb_pkg::TW-1:0]  slot_c, w1l_c, w0l_c, msr_c, low_c;
  logic                    slot_end, bit_one;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      frm_m_r <= 1'b0;
      frm_s_r <= 1'b0;
      ow_m_r  <= 1'b1;
      ow_s_r  <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      frm_m_r <= frame_i;
      frm_s_r <= frm_m_r;
      ow_m_r  <= ow_i;
      ow_s_r  <= ow_m_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign lsb_fall = scl_fall && (bit_cnt_r == swb_pkg::ACK_BIT) && !ack_ph_r;
  assign ack_fall = scl_fall && ack_ph_r;
  assign code_wr  = (sh_r == swb_pkg::CMD_WRITE_BYTE) && !busy_r;
  assign code_rd  = (sh_r == swb_pkg::CMD_READ_BYTE) && !busy_r;
  // Write starts only once the whole data byte is in
  assign go_wr    = (hst_r == H_DATA) && lsb_fall;
  assign go_rd    = (hst_r == H_RWAIT) && ack_fall;
  assign start    = go_wr | go_rd;
  assign ack_go   = lsb_fall && (((hst_r == H_CODE) && (code_wr | code_rd)) || (hst_r == H_DATA));

  ////////////////////////////////////////////////////////////////////////
  // Host byte framing, acknowledge and command decode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hst_r     <= H_IDLE;
      bit_cnt_r <= '0;
      sh_r      <= '0;
      ack_ph_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else if (!frm_s_r) begin
      hst_r     <= H_IDLE;
      bit_cnt_r <= '0;
      ack_ph_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else begin
      if (scl_rise && (bit_cnt_r < swb_pkg::ACK_BIT)) begin
        sh_r      <= {sh_r[6:0], sda_s_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (lsb_fall) begin
        ack_ph_r <= 1'b1;
        sda_oe_r <= ack_go;
      end else if (ack_fall) begin
        ack_ph_r  <= 1'b0;
        sda_oe_r  <= 1'b0;
        bit_cnt_r <= '0;
      end
      case (hst_r)
        H_IDLE: begin
          hst_r <= H_CODE;
        end
        H_CODE: begin
          if (lsb_fall) begin
            if (code_wr) begin
              hst_r <= H_DATA;
            end else if (code_rd) begin
              hst_r <= H_RWAIT;
            end else begin
              hst_r <= H_DROP;
            end
          end
        end
        H_DATA: begin
          if (go_wr) begin
            hst_r <= H_DROP;
          end
        end
        H_RWAIT: begin
          if (go_rd) begin
            hst_r <= H_DROP;
          end
        end
        H_DROP: begin
          hst_r <= H_DROP;
        end
        default: begin
          hst_r <= H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot timing, speed chosen at command start
  assign slot_c   = od_r ? OD_SLOT_C : STD_SLOT_C;
  assign w0l_c    = od_r ? OD_W0L_C : STD_W0L_C;
  assign w1l_c    = od_r ? OD_W1L_C : STD_W1L_C;
  assign msr_c    = od_r ? OD_MSR_C : STD_MSR_C;
  // Read slots are write-one slots
  assign bit_one  = rd_cmd_r | tx_r[idx_r];
  assign low_c    = bit_one ? w1l_c : w0l_c;
  assign slot_end = (wst_r == W_SLOT) && (tmr_r == slot_c - swb_pkg::TW'(1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wst_r     <= W_IDLE;
      tmr_r     <= '0;
      idx_r     <= '0;
      tx_r      <= '0;
      rd_cmd_r  <= 1'b0;
      od_r      <= 1'b0;
      spu_lat_r <= 1'b0;
      apu_lat_r <= 1'b0;
      busy_r    <= 1'b0;
    end else if (start && (wst_r == W_IDLE)) begin
      wst_r     <= W_SLOT;
      tmr_r     <= '0;
      idx_r     <= '0;
      tx_r      <= go_wr ? sh_r : '1;
      rd_cmd_r  <= go_rd;
      od_r      <= overdrive_speed_select_i;
      spu_lat_r <= go_wr & strong_pullup_enable_i;
      apu_lat_r <= active_pullup_enable_i;
      busy_r    <= 1'b1;
    end else if (wst_r == W_SLOT) begin
      if (slot_end) begin
        tmr_r <= '0;
        if (idx_r == swb_pkg::LAST_IDX) begin
          wst_r  <= W_IDLE;
          busy_r <= 1'b0;
        end else begin
          idx_r <= idx_r + 3'h1;
        end
      end else begin
        tmr_r <= tmr_r + swb_pkg::TW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus drive, sampling and pullups
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ow_oe_r <= 1'b0;
      apu_r   <= 1'b0;
      zero_r  <= 1'b0;
    end else begin
      ow_oe_r <= (wst_r == W_SLOT) && (tmr_r < low_c);
      apu_r   <= apu_lat_r && (wst_r == W_SLOT) && (tmr_r >= low_c) && (tmr_r < low_c + APU_C);
      zero_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_r      <= '0;
      rd_data_r <= '0;
    end else begin
      if ((wst_r == W_SLOT) && (tmr_r == msr_c)) begin
        rx_r[idx_r] <= ow_s_r;
      end
      if (slot_end && (idx_r == swb_pkg::LAST_IDX) && rd_cmd_r) begin
        rd_data_r <= rx_r;
      end
    end
  end

  // Strong pullup after a write byte, until the next command or until strong_pullup_enable_i is cleared
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spu_r <= 1'b0;
    end else if (start) begin
      spu_r <= 1'b0;
    end else if (slot_end && (idx_r == swb_pkg::LAST_IDX)) begin
      spu_r <= spu_lat_r;
    end else begin
      spu_r <= spu_r & strong_pullup_enable_i;
    end
  end

  // Read pointer: status after each byte command
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_r <= swb_pkg::PTR_RST;
    end else if (start) begin
      ptr_r <= 1'b1;
    end else if (ptr_sel_data_i) begin
      ptr_r <= 1'b0;
    end
  end

  // Busy length counter, checked below
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cyc_r <= '0;
    end else if (start && !busy_r) begin
      busy_cyc_r <= '0;
    end else if (busy_r) begin
      busy_cyc_r <= busy_cyc_r + (swb_pkg::TW+4)'(1);
    end
  end

  assign sda_o           = zero_r;
  assign sda_oe_o        = sda_oe_r;
  assign ow_o            = zero_r;
  assign ow_oe_o         = ow_oe_r;
  assign spu_o           = spu_r;
  assign apu_o           = apu_r;
  assign bus_busy_flag_o = busy_r;
  assign read_data_o     = rd_data_r;
  assign ptr_status_o    = ptr_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int LAT = swb_pkg::LAT_CYC;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_ack_not_busy: assert property (ack_go |-> !busy_r || hst_r == H_DATA)
    else $error("acknowledge given while busy");
  a_rd_no_ack: assert property (lsb_fall && hst_r == H_CODE && busy_r |=> !sda_oe_r)
    else $error("read code acknowledged while busy");
  a_wr_start_lat: assert property (go_wr |-> ##[1:LAT] ow_oe_r && busy_r)
    else $error("write activity late");
  a_rd_start_lat: assert property (go_rd |-> ##[1:LAT] ow_oe_r && busy_r)
    else $error("read activity late");
  a_busy_length: assert property ($fell(busy_r) |-> busy_cyc_r == swb_pkg::SLOTS * slot_c)
    else $error("busy length not eight slots");
  a_byte_taken: assert property ($rose(busy_r) && !rd_cmd_r |-> tx_r == $past(sh_r))
    else $error("sent byte differs from received byte");
  a_read_one: assert property (rd_cmd_r && wst_r == W_SLOT && tmr_r == w1l_c |=> !ow_oe_r)
    else $error("read slot low too long");
  a_ptr_status: assert property ($rose(busy_r) |-> ptr_r [*2])
    else $error("pointer not on status");
  a_spu_after: assert property ($fell(busy_r) && spu_lat_r && strong_pullup_enable_i |-> spu_r)
    else $error("strong pullup missing");
  a_rd_store: assert property ($fell(busy_r) && rd_cmd_r |-> rd_data_r == $past(rx_r))
    else $error("read data not stored");

  c_write: cover property (go_wr ##1 busy_r);
  c_read: cover property (go_rd ##1 busy_r);
  c_reject: cover property (lsb_fall && hst_r == H_CODE && busy_r);
  c_done: cover property ($fell(busy_r) && rd_cmd_r);
endmodule

/* File: sim/swb_host_model.sv */
/*
  Host link model: frames command bytes MSB first, clocks the ack bit.
  Assumes the bench resolves the open-drain data line into sda_line_i.
*/
`timescale 1ns/1ps
module swb_host_model (
  // Host link
  output logic      scl_o,
  output logic      sda_o,
  output logic      frame_o,
  input  wire logic sda_line_i
);
  realtime last_fall;

  initial begin
    scl_o <= 1'b1;
    sda_o <= 1'b1;
    frame_o <= 1'b0;
    last_fall = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One link clock of 400 ns, line sampled mid high phase
  // Pins change just after the system clock edge they land on
  task automatic put_bit(input logic v, output logic s);
    scl_o <= 1'b0;
    last_fall = $realtime;
    sda_o <= v;
    #200;
    scl_o <= 1'b1;
    #100;
    s = sda_line_i;
    #100;
  endtask

  // Byte MSB first, then released ack clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic frame_begin;
    frame_o <= 1'b1;
    #200;
  endtask

  // Closing fall ends the ack clock, then clock stands high
  task automatic frame_end;
    scl_o <= 1'b0;
    last_fall = $realtime;
    sda_o <= 1'b1;
    #200;
    scl_o <= 1'b1;
    #200;
    frame_o <= 1'b0;
    #400;
  endtask
endmodule

/* File: sim/testbench.sv */
/*
  Testbench for the byte write/read engine: host commands, bus slave, checks.
  Assumes shortened standard slot timing set at the instance.
*/
`timescale 1ns/1ps
module testbench;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       od = 1'b0, spu_en = 1'b0, apu_en = 1'b0, ptr_sel = 1'b0, ow_i = 1'b1;
  logic       scl, sda_h, frame, sda_o, sda_oe, ow_o, ow_oe, strong_pullup_enable, active_pullup_enable, busy, ptr, oe_q = 1'b0, armed = 1'b0;
  logic       a1, a2, apu_q = 1'b0;
  logic [7:0] rd;
  logic [7:0] pat = 8'hFF;
  wire        sda_line = sda_oe ? sda_o : sda_h;
  int         fails = 0, checks = 0, idx = 0, hold = 0, busy_cnt = 0, low_cnt = 0, apu_n = 0;
  int         lows[$];

  always #25 clk_i = ~clk_i;

  swb_host_model i_host (.scl_o(scl), .sda_o(sda_h), .frame_o(frame), .sda_line_i(sda_line));

  swb_engine #(.STD_SLOT_NS(2000), .STD_W0L_NS(1500), .STD_W1L_NS(300), .STD_MSR_NS(600)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_line), .frame_i(frame),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .overdrive_speed_select_i(od), .strong_pullup_enable_i(spu_en),
    .active_pullup_enable_i(apu_en), .ptr_sel_data_i(ptr_sel), .ow_i(ow_i), .ow_o(ow_o), .ow_oe_o(ow_oe),
    .spu_o(strong_pullup_enable), .apu_o(active_pullup_enable), .bus_busy_flag_o(busy), .read_data_o(rd), .ptr_status_o(ptr));

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: holds line low past the sample point in slots whose pattern bit is 0
  always @(posedge clk_i) begin
    oe_q <= ow_oe;
    apu_q <= active_pullup_enable;
    if (ow_oe && !oe_q) begin
      hold <= pat[idx[2:0]] ? 0 : (od ? 60 : 20);
      idx <= idx + 1;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end
    ow_i <= !(ow_oe || hold != 0);
    if (busy) busy_cnt++;
    if (active_pullup_enable && !apu_q) apu_n++;
    if (ow_oe) begin
      low_cnt++;
    end else if (low_cnt != 0) begin
      lows.push_back(low_cnt);
      low_cnt = 0;
    end
  end

  // First bus activity after the reference link clock fall
  always @(posedge ow_oe) begin
    if (armed) begin
      check(($realtime - i_host.last_fall) <= 262.5, 1);
      armed = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic start_cmd(input logic [7:0] p);
    lows.delete();
    busy_cnt = 0;
    apu_n = 0;
    idx = 0;
    pat = p;
    armed = 1'b1;
  endtask

  task automatic cmd(input logic [7:0] code, input logic [7:0] data, input logic has_data);
    a2 = 1'b0;
    i_host.frame_begin();
    i_host.send_byte(code, a1);
    if (has_data) i_host.send_byte(data, a2);
    i_host.frame_end();
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 5000) begin
      fails++;
      report_and_stop();
    end
    repeat (3) @(posedge clk_i);
  endtask

  // Low time per slot, LSB first
  task automatic check_slots(input logic [7:0] b, input int one_c, input int zero_c);
    check(lows.size(), 8);
    for (int i = 0; i < 8 && i < lows.size(); i++) check(lows[i], b[i] ? one_c : zero_c);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({busy, ow_oe, strong_pullup_enable, sda_oe, sda_o, ow_o, active_pullup_enable}, 0);
    check(ptr, 1);
    // Overdrive write with both pullups, read refused meanwhile
    od <= 1'b1;
    spu_en <= 1'b1;
    apu_en <= 1'b1;
    @(posedge clk_i);
    start_cmd(8'hFF);
    cmd(8'hA5, 8'h3C, 1'b1);
    check({a1, a2}, 2'h3);
    cmd(8'h96, 8'h00, 1'b0);
    check(a1, 0);
    wait_idle();
    check(busy_cnt, 1600);
    check_slots(8'h3C, 20, 150);
    check(apu_n, 8);
    check(strong_pullup_enable, 1);
    check(ptr, 1);
    // Standard read, write refused meanwhile
    @(posedge clk_i);
    od <= 1'b0;
    spu_en <= 1'b0;
    apu_en <= 1'b0;
    @(posedge clk_i);
    start_cmd(8'hA6);
    cmd(8'h96, 8'h00, 1'b0);
    check(a1, 1);
    cmd(8'hA5, 8'h00, 1'b1);
    check({a1, a2}, 2'h0);
    wait_idle();
    check(busy_cnt, 320);
    check_slots(8'hFF, 6, 30);
    check(rd, 8'hA6);
    check(ptr, 1);
    @(posedge clk_i);
    ptr_sel <= 1'b1;
    @(posedge clk_i);
    ptr_sel <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(ptr, 0);
    // Overdrive read puts pointer back on status
    od <= 1'b1;
    @(posedge clk_i);
    start_cmd(8'h59);
    cmd(8'h96, 8'h00, 1'b0);
    check(a1, 1);
    wait_idle();
    check(busy_cnt, 1600);
    check_slots(8'hFF, 20, 150);
    check(rd, 8'h59);
    check(ptr, 1);
    report_and_stop();
  end
endmodule
